// ### verif/imr_regs_monitor.sv
// Purpose: Port assertions for the register bank
// Assumes: Sees only the ports of imr_regs, one clock domain
// Notes:   Bound from the testbench top file
`timescale 1ns/1ps
module imr_regs_monitor (
  input wire logic       sys_clk,
  input wire logic       rst_n,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic       alarm_pin,
  input wire logic [1:0] scan_policy,
  input wire logic [2:0] manual_channel,
  input wire logic       config_error,
  input wire logic       scan_launch_pulse,
  input wire logic       scan_abort_pulse,
  input wire logic [3:0] pair_joined,
  input wire logic [3:0] pair_pseudo_diff,
  input wire logic [3:0] pair_neg_common,
  input wire logic [3:0] pair_half_ref,
  input wire logic [2:0] positive_mux_output,
  input wire logic [2:0] negative_mux_output,
  input wire logic       negative_mux_common
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  rd_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data not zero outside a read");
  ctrl_read_a: assert property ($past(reg_rd) && $past(reg_addr) == 8'h1c |->
    reg_rdata == {4'h0, $past(alarm_pin), $past(config_error), $past(scan_policy)})
    else $error("scan control read value wrong");
  common_read_a: assert property ($past(reg_rd) && $past(reg_addr) == 8'h27
    |-> reg_rdata[7:1] == 7'h00) else $error("common register reserved bits set");
  policy_wr_a: assert property (reg_wr && reg_addr == 8'h1c |=>
    scan_policy == $past(reg_wdata[1:0])) else $error("scan policy not written");
  channel_wr_a: assert property (reg_wr && reg_addr == 8'h1d |=>
    manual_channel == $past(reg_wdata[2:0])) else $error("manual channel not written");
  launch_pulse_a: assert property (reg_wr && reg_addr == 8'h1e |=>
    scan_launch_pulse == $past(reg_wdata[0] & scan_policy[1]))
    else $error("launch pulse wrong");
  abort_pulse_a: assert property (reg_wr && reg_addr == 8'h1f && reg_wdata[0]
    |=> scan_abort_pulse == $past(scan_policy[1])) else $error("abort pulse wrong");
  neg_common_a: assert property (reg_wr && reg_addr == 8'h24 |=> ##1
    pair_neg_common == ~{^$past(reg_wdata[1:0], 2), ^$past(reg_wdata[3:2], 2),
    ^$past(reg_wdata[5:4], 2), ^$past(reg_wdata[7:6], 2)})
    else $error("common pin use disagrees with pairing");
  pseudo_pair_a: assert property ((pair_pseudo_diff & ~pair_joined) == 4'h0)
    else $error("pseudo pair not joined");
  half_ref_a: assert property ((pair_half_ref & ~pair_neg_common) == 4'h0)
    else $error("half reference on a joined pair");
  route_pair_a: assert property (!negative_mux_common |-> !positive_mux_output[0]
    && negative_mux_output == (positive_mux_output | 3'h1)) else $error("pair routing wrong");
  route_com_a: assert property (negative_mux_common |-> negative_mux_output == 3'h0)
    else $error("negative output not idle on common pin");

  launch_c: cover property (scan_launch_pulse);
  abort_c: cover property (scan_abort_pulse);
  joined_c: cover property (!negative_mux_common);
  alarm_c: cover property (reg_rdata[3]);
endmodule // imr_regs_monitor

// ### verif/imr_regs_tb.sv
// Purpose: Self-checking bench for the input mux and scan mode registers
// Assumes: Register port with read data one cycle after the strobe
// Notes:   Routing outputs are checked two cycles after a write
`timescale 1ns/1ps
module imr_regs_tb;
  logic       sys_clk, rst_n, reg_wr, reg_rd, alarm_pin;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, scan_mask, scan_repeat;
  logic [1:0] scan_policy;
  logic [2:0] manual_channel, positive_mux_output, negative_mux_output;
  logic       instant_select_en, scan_launch_pulse, scan_abort_pulse;
  logic       scan_running, config_error, negative_mux_common;
  logic [3:0] pair_joined, pair_pseudo_diff, pair_neg_common, pair_half_ref;
  int         mismatches, checks_done;

  imr_regs i_imr_regs (.*);

  task automatic chk(string n, logic [7:0] e, logic [7:0] s);
    checks_done++;
    if (s !== e) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic wt(int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  task automatic wr(logic [7:0] a, logic [7:0] d);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge sys_clk);
    reg_wr    <= 1'b0;
    #1;
  endtask
  task automatic rd(logic [7:0] a, logic [7:0] e, string n);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge sys_clk);
    reg_rd   <= 1'b0;
    #1;
    chk(n, e, reg_rdata);
  endtask

  task automatic t_reset;
    logic [7:0] a[10] = '{8'h1c, 8'h1d, 8'h1e, 8'h1f, 8'h24, 8'h27, 8'h2a, 8'h80, 8'h82, 8'h55};
    foreach (a[i]) rd(a[i], 8'h00, "reset value");
    chk("neg common", 8'h0f, {4'h0, pair_neg_common});
    $display("test reset done");
  endtask
  task automatic t_regs;
    wr(8'h80, 8'ha5);
    rd(8'h80, 8'ha5, "mask");
    chk("mask out", 8'ha5, scan_mask);
    wr(8'h82, 8'h3c);
    rd(8'h82, 8'h3c, "repeat");
    chk("repeat out", 8'h3c, scan_repeat);
    wr(8'h2a, 8'hff);
    rd(8'h2a, 8'h01, "instant");
    chk("instant out", 8'h01, {7'h0, instant_select_en});
    wr(8'h27, 8'hff);
    rd(8'h27, 8'h01, "common");
    wr(8'h1d, 8'hfd);
    rd(8'h1d, 8'h05, "channel");
    $display("test regs done");
  endtask
  task automatic t_modes;
    for (int m = 0; m < 4; m++) begin
      wr(8'h1c, {6'h00, m[1:0]});
      rd(8'h1c, {6'h00, m[1:0]}, "policy");
      wr(8'h1e, 8'h01);
      chk("launch", {7'h0, m[1]}, {7'h0, scan_launch_pulse});
      chk("running", {7'h0, m[1]}, {7'h0, scan_running});
      wr(8'h1f, 8'h01);
      chk("launch end", 8'h00, {7'h0, scan_launch_pulse});
      chk("abort", {7'h0, m[1]}, {7'h0, scan_abort_pulse});
      chk("running end", 8'h00, {7'h0, scan_running});
    end
    wr(8'h1c, 8'h03);
    wr(8'h1e, 8'h01);
    wr(8'h1d, 8'h05);
    chk("fallback policy", 8'h00, {6'h0, scan_policy});
    chk("fallback abort", 8'h01, {7'h0, scan_abort_pulse});
    chk("fallback running", 8'h00, {7'h0, scan_running});
    wr(8'h1c, 8'h00);
    $display("test modes done");
  endtask
  task automatic t_flags;
    wr(8'h80, 8'h00);
    wr(8'h1c, 8'h02);
    wt(2);
    rd(8'h1c, 8'h06, "error set");
    chk("error out", 8'h01, {7'h0, config_error});
    alarm_pin <= 1'b1;
    wr(8'h80, 8'h01);
    wt(2);
    rd(8'h1c, 8'h0a, "alarm high");
    alarm_pin <= 1'b0;
    rd(8'h1c, 8'h02, "alarm low");
    wr(8'h1c, 8'h00);
    $display("test flags done");
  endtask
  task automatic t_pair;
    logic [3:0] j;
    wr(8'h27, 8'h01);
    for (int v = 0; v < 4; v++) begin
      wr(8'h24, {4{v[1:0]}});
      j = (v == 1 || v == 2) ? 4'hf : 4'h0;
      wt(2);
      chk("joined", {4'h0, j}, {4'h0, pair_joined});
      chk("pseudo", (v == 2) ? 8'h0f : 8'h00, {4'h0, pair_pseudo_diff});
      chk("half ref", {4'h0, ~j}, {4'h0, pair_half_ref});
      chk("neg common", {4'h0, ~j}, {4'h0, pair_neg_common});
      rd(8'h24, {4{v[1:0]}}, "pairing");
    end
    wr(8'h24, 8'h1b);
    wr(8'h1d, 8'h02);
    wt(2);
    chk("pair map", 8'h06, {4'h0, pair_joined});
    chk("pos mux", 8'h02, {5'h0, positive_mux_output});
    chk("neg mux", 8'h03, {5'h0, negative_mux_output});
    wr(8'h1d, 8'h00);
    wt(2);
    chk("mux common", 8'h01, {7'h0, negative_mux_common});
    $display("test pair done");
  endtask

  task automatic test_done;
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  initial begin
    sys_clk = 1'b0;
    forever #2.5 sys_clk = ~sys_clk;
  end
  initial begin
    rst_n     = 1'b0;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    reg_addr  = 8'h00;
    reg_wdata = 8'h00;
    alarm_pin = 1'b0;
    repeat (8) @(posedge sys_clk);
    rst_n <= 1'b1;
    wt(1);
    t_reset;
    t_regs;
    t_modes;
    t_flags;
    t_pair;
    test_done;
  end
  initial begin
    #20000;
    mismatches++;
    test_done;
  end
endmodule // imr_regs_tb

bind imr_regs imr_regs_monitor i_imr_regs_monitor (.*);

// ### verilog/imr_pair_route.sv
// Purpose: Decodes pairing fields into mux routing per input pair
// Assumes: Pairing byte as held by the register bank
// Notes:   Purely combinational
`timescale 1ns/1ps
module imr_pair_route
  import imr_pkg::*;
(
  imr_route_if.route rt
);
  logic [1:0] sel_pair;

  for (genvar p = 0; p < IMR_PAIRS; p++) begin : g_pair
    logic [1:0] setting;
    assign setting = rt.pairing[7-2*p -: 2];
    assign rt.joined[p]      = (setting == IMR_PAIR_SINGLE) ||
                               (setting == IMR_PAIR_PSEUDO);
    assign rt.pseudo_diff[p] = (setting == IMR_PAIR_PSEUDO);
    assign rt.neg_common[p]  = !rt.joined[p];
    assign rt.half_ref[p]    = !rt.joined[p] && rt.half_ref_mode;
  end

  assign sel_pair = rt.channel[2:1];

  always_comb begin
    if (rt.joined[sel_pair]) begin
      rt.pos_sel        = {sel_pair, 1'b0};
      rt.neg_sel        = {sel_pair, 1'b1};
      rt.neg_mux_common = 1'b0;
    end else begin
      rt.pos_sel        = rt.channel;
      rt.neg_sel        = 3'h0;
      rt.neg_mux_common = 1'b1;
    end
  end
endmodule // imr_pair_route

// ### verilog/imr_pkg.sv
// Purpose: Constants for the input multiplexer and scan mode register bank
// Assumes: Byte wide registers, 8-bit register addresses
// Notes:   Offsets, field positions and reset values live here
// Functional notes
// - Pairing fields reset to 00b; 00b keeps both inputs independent
// - Pairing 00b takes the negative mux output from the common pin
// - Pairing 01b: single-ended pair, even input positive, odd negative
// - Pairing 10b: pseudo-differential pair, even positive, odd negative
// - Common-mode bit affects only pairs set to 00b or 11b
// - Common-mode bit resets 0; 0 ground referred, 1 half-reference referred
// - Common-mode register bits 7-1 read as zero
// - Scan-control bits 7-4 read zero; software leaves them unwritten
// - Scan-control bit 3 reads the alarm pin level, resets 0
// - Scan-control bit 2 flags a configuration error, resets 0
// - Scan policy bits 1-0 reset 00b: manual, on-the-fly, auto, custom
// - Scan-control register decodes at 1Ch
// - Manual channel select register decodes at 1Dh
// - Scan launch register decodes at 1Eh
// - Scan abort register decodes at 1Fh
// - Instant select enable register decodes at 2Ah
// - Scan channel mask register decodes at 80h
// - Scan repeat control register decodes at 82h
// - Common-mode register decodes at 27h and resets to 00h
package imr_pkg;
  localparam logic [7:0] IMR_ADDR_SCAN_CTRL   = 8'h1c;
  localparam logic [7:0] IMR_ADDR_MANUAL_CH   = 8'h1d;
  localparam logic [7:0] IMR_ADDR_LAUNCH      = 8'h1e;
  localparam logic [7:0] IMR_ADDR_ABORT       = 8'h1f;
  localparam logic [7:0] IMR_ADDR_PAIRING     = 8'h24;
  localparam logic [7:0] IMR_ADDR_COMMON      = 8'h27;
  localparam logic [7:0] IMR_ADDR_INSTANT     = 8'h2a;
  localparam logic [7:0] IMR_ADDR_MASK        = 8'h80;
  localparam logic [7:0] IMR_ADDR_REPEAT      = 8'h82;

  localparam int         IMR_PAIRS            = 4;
  localparam int         IMR_POS_ALERT        = 3;
  localparam int         IMR_POS_ERROR        = 2;
  localparam int         IMR_POS_START        = 0;

  localparam logic [7:0] IMR_RST_PAIRING      = 8'h00;
  localparam logic       IMR_RST_COMMON       = 1'b0;
  localparam logic [2:0] IMR_RST_MANUAL_CH    = 3'h0;
  localparam logic       IMR_RST_INSTANT      = 1'b0;
  localparam logic [7:0] IMR_RST_MASK         = 8'h00;
  localparam logic [7:0] IMR_RST_REPEAT       = 8'h00;

  typedef enum logic [1:0] {
    IMR_PAIR_SEPARATE = 2'b00,
    IMR_PAIR_SINGLE   = 2'b01,
    IMR_PAIR_PSEUDO   = 2'b10,
    IMR_PAIR_SAME_00  = 2'b11
  } imr_pair_type;

  typedef enum logic [1:0] {
    IMR_SCAN_MANUAL   = 2'b00,
    IMR_SCAN_INSTANT  = 2'b01,
    IMR_SCAN_AUTO     = 2'b10,
    IMR_SCAN_CUSTOM   = 2'b11
  } imr_scan_type;

  localparam imr_scan_type IMR_RST_SCAN       = IMR_SCAN_MANUAL;
endpackage

// ### verilog/imr_regs.sv
// Purpose: Register bank for input pairing, common pin and scan mode
// Assumes: Plain register port, read data one cycle after the read strobe
// Notes:   Sequencing itself lives outside; this bank issues launch and abort pulses
`timescale 1ns/1ps
module imr_regs
  import imr_pkg::*;
(
  input  wire logic       sys_clk,
  input  wire logic       rst_n,
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  output logic      [7:0] reg_rdata,
  input  wire logic       alarm_pin,
  output logic      [1:0] scan_policy,
  output logic      [2:0] manual_channel,
  output logic            instant_select_en,
  output logic      [7:0] scan_mask,
  output logic      [7:0] scan_repeat,
  output logic            scan_launch_pulse,
  output logic            scan_abort_pulse,
  output logic            scan_running,
  output logic            config_error,
  output logic      [3:0] pair_joined,
  output logic      [3:0] pair_pseudo_diff,
  output logic      [3:0] pair_neg_common,
  output logic      [3:0] pair_half_ref,
  output logic      [2:0] positive_mux_output,
  output logic      [2:0] negative_mux_output,
  output logic            negative_mux_common
);
  logic [7:0]   input_pairing_q;
  logic         common_mode_q;
  imr_scan_type scan_policy_q;
  logic [2:0]   manual_channel_q;
  logic         instant_q;
  logic [7:0]   mask_q;
  logic [7:0]   repeat_q;
  logic         launch_q;
  logic         abort_q;
  logic         running_q;
  logic         error_q;
  logic         error_d;
  logic [7:0]   rdata_q;
  logic [7:0]   rdata_d;
  logic [3:0]   joined_q;
  logic [3:0]   pseudo_q;
  logic [3:0]   neg_common_q;
  logic [3:0]   half_ref_q;
  logic [2:0]   pos_q;
  logic [2:0]   neg_q;
  logic         neg_mux_common_q;
  logic         seq_policy;
  logic         wr_scan_ctrl;
  logic         wr_manual;
  logic         wr_launch;
  logic         wr_abort;
  logic         wr_pairing;
  logic         wr_common;
  logic         wr_instant;
  logic         wr_mask;
  logic         wr_repeat;

  imr_route_if rt ();

  imr_pair_route i_imr_pair_route (
    .rt (rt.route)
  );

  assign rt.pairing       = input_pairing_q;
  assign rt.half_ref_mode = common_mode_q;
  assign rt.channel       = manual_channel_q;

  assign seq_policy   = (scan_policy_q == IMR_SCAN_AUTO) ||
                        (scan_policy_q == IMR_SCAN_CUSTOM);
  assign wr_scan_ctrl = reg_wr && (reg_addr == IMR_ADDR_SCAN_CTRL);
  assign wr_manual    = reg_wr && (reg_addr == IMR_ADDR_MANUAL_CH);
  assign wr_launch    = reg_wr && (reg_addr == IMR_ADDR_LAUNCH);
  assign wr_abort     = reg_wr && (reg_addr == IMR_ADDR_ABORT);
  assign wr_pairing   = reg_wr && (reg_addr == IMR_ADDR_PAIRING);
  assign wr_common    = reg_wr && (reg_addr == IMR_ADDR_COMMON);
  assign wr_instant   = reg_wr && (reg_addr == IMR_ADDR_INSTANT);
  assign wr_mask      = reg_wr && (reg_addr == IMR_ADDR_MASK);
  assign wr_repeat    = reg_wr && (reg_addr == IMR_ADDR_REPEAT);

  // Pairing register
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      input_pairing_q <= IMR_RST_PAIRING;
    end else if (wr_pairing) begin
      input_pairing_q <= reg_wdata;
    end
  end

  // Common pin setup, only bit 0 is stored
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      common_mode_q <= IMR_RST_COMMON;
    end else if (wr_common) begin
      common_mode_q <= reg_wdata[0];
    end
  end

  // Scan policy; a channel write under auto or custom policy falls back to manual
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      scan_policy_q <= IMR_RST_SCAN;
    end else if (wr_scan_ctrl) begin
      scan_policy_q <= imr_scan_type'(reg_wdata[1:0]);
    end else if (wr_manual && seq_policy) begin
      scan_policy_q <= IMR_SCAN_MANUAL;
    end
  end

  // Manual channel select
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      manual_channel_q <= IMR_RST_MANUAL_CH;
    end else if (wr_manual) begin
      manual_channel_q <= reg_wdata[2:0];
    end
  end

  // Instant select enable
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      instant_q <= IMR_RST_INSTANT;
    end else if (wr_instant) begin
      instant_q <= reg_wdata[0];
    end
  end

  // Auto sequence mask
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      mask_q <= IMR_RST_MASK;
    end else if (wr_mask) begin
      mask_q <= reg_wdata;
    end
  end

  // Auto sequence repeat control
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      repeat_q <= IMR_RST_REPEAT;
    end else if (wr_repeat) begin
      repeat_q <= reg_wdata;
    end
  end

  // Launch pulse, ignored outside auto and custom policy
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      launch_q <= 1'b0;
    end else begin
      launch_q <= wr_launch && seq_policy && reg_wdata[IMR_POS_START];
    end
  end

  // Abort pulse, also sent when a channel write cuts a running sequence
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      abort_q <= 1'b0;
    end else begin
      abort_q <= (wr_abort && seq_policy && reg_wdata[IMR_POS_START]) ||
                 (wr_manual && seq_policy && running_q);
    end
  end

  // Sequence running flag; launch wins over any clear
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      running_q <= 1'b0;
    end else if (wr_launch && seq_policy && reg_wdata[IMR_POS_START]) begin
      running_q <= 1'b1;
    end else if ((wr_abort && reg_wdata[IMR_POS_START]) || wr_manual || !seq_policy) begin
      running_q <= 1'b0;
    end
  end

  // Configuration fault detection
  always_comb begin
    error_d = 1'b0;
    if ((scan_policy_q == IMR_SCAN_AUTO) && (mask_q == 8'h00)) begin
      error_d = 1'b1;
    end
    if (rt.joined[manual_channel_q[2:1]] && manual_channel_q[0]) begin
      error_d = 1'b1;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      error_q <= 1'b0;
    end else begin
      error_q <= error_d;
    end
  end

  // Registered per pair routing flags
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      joined_q     <= 4'h0;
      pseudo_q     <= 4'h0;
      neg_common_q <= 4'hf;
      half_ref_q   <= 4'h0;
    end else begin
      joined_q     <= rt.joined;
      pseudo_q     <= rt.pseudo_diff;
      neg_common_q <= rt.neg_common;
      half_ref_q   <= rt.half_ref;
    end
  end

  // Registered mux output selection
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pos_q            <= 3'h0;
      neg_q            <= 3'h0;
      neg_mux_common_q <= 1'b1;
    end else begin
      pos_q            <= rt.pos_sel;
      neg_q            <= rt.neg_sel;
      neg_mux_common_q <= rt.neg_mux_common;
    end
  end

  // Read multiplexer; unmapped and write-only addresses read zero
  always_comb begin
    rdata_d = 8'h00;
    case (reg_addr)
      IMR_ADDR_SCAN_CTRL: begin
        rdata_d[1:0]           = scan_policy_q;
        rdata_d[IMR_POS_ERROR] = error_q;
        rdata_d[IMR_POS_ALERT] = alarm_pin;
      end
      IMR_ADDR_MANUAL_CH: begin
        rdata_d[2:0] = manual_channel_q;
      end
      IMR_ADDR_PAIRING: begin
        rdata_d = input_pairing_q;
      end
      IMR_ADDR_COMMON: begin
        rdata_d[0] = common_mode_q;
      end
      IMR_ADDR_INSTANT: begin
        rdata_d[0] = instant_q;
      end
      IMR_ADDR_MASK: begin
        rdata_d = mask_q;
      end
      IMR_ADDR_REPEAT: begin
        rdata_d = repeat_q;
      end
      default: begin
        rdata_d = 8'h00;
      end
    endcase
  end

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_q <= 8'h00;
    end else if (reg_rd) begin
      rdata_q <= rdata_d;
    end else begin
      rdata_q <= 8'h00;
    end
  end

  assign reg_rdata           = rdata_q;
  assign scan_policy         = scan_policy_q;
  assign manual_channel      = manual_channel_q;
  assign instant_select_en   = instant_q;
  assign scan_mask           = mask_q;
  assign scan_repeat         = repeat_q;
  assign scan_launch_pulse   = launch_q;
  assign scan_abort_pulse    = abort_q;
  assign scan_running        = running_q;
  assign config_error        = error_q;
  assign pair_joined         = joined_q;
  assign pair_pseudo_diff    = pseudo_q;
  assign pair_neg_common     = neg_common_q;
  assign pair_half_ref       = half_ref_q;
  assign positive_mux_output = pos_q;
  assign negative_mux_output = neg_q;
  assign negative_mux_common = neg_mux_common_q;
endmodule // imr_regs

// ### verilog/imr_route_if.sv
// Purpose: Carries pairing setup to the router and routing back
// Assumes: Four input pairs, eight inputs
// Notes:   Per pair router outputs are nets, one bit per pair; mux selects are variables
`timescale 1ns/1ps
interface imr_route_if;
  logic [7:0] pairing;
  logic       half_ref_mode;
  logic [2:0] channel;
  wire  [3:0] joined;
  wire  [3:0] pseudo_diff;
  wire  [3:0] neg_common;
  wire  [3:0] half_ref;
  logic [2:0] pos_sel;
  logic [2:0] neg_sel;
  logic       neg_mux_common;

  modport cfg (
    output pairing,
    output half_ref_mode,
    output channel,
    input  joined,
    input  pseudo_diff,
    input  neg_common,
    input  half_ref,
    input  pos_sel,
    input  neg_sel,
    input  neg_mux_common
  );
  modport route (
    input  pairing,
    input  half_ref_mode,
    input  channel,
    output joined,
    output pseudo_diff,
    output neg_common,
    output half_ref,
    output pos_sel,
    output neg_sel,
    output neg_mux_common
  );
endinterface
